//--- inc/dmm_pkg.sv
/*
   Shared constants, types and helper functions of the four-channel
   direct memory mover: register map, field layouts, reset values,
   address windows and trigger select codes.
   Assumes a 16-bit byte-addressed data space with an 8-bit data bus.
*/
package dmm_pkg;

   localparam int NCH = 4;
   localparam int NEVT = 8;
   localparam int AW = 16;
   localparam int RAW = 6;
   localparam int DW = 32;

   typedef logic [AW-1:0] dmm_addr_t;

   // per-channel register index, word address is {0, ch, idx}
   localparam logic [2:0] R_CFG = 3'h0;
   localparam logic [2:0] R_BLK = 3'h1;
   localparam logic [2:0] R_RPT = 3'h2;
   localparam logic [2:0] R_SRC = 3'h3;
   localparam logic [2:0] R_DST = 3'h4;
   localparam logic [2:0] R_CSRC = 3'h5;
   localparam logic [2:0] R_CDST = 3'h6;
   localparam logic [2:0] R_LEFT = 3'h7;

   // global registers
   localparam logic [RAW-1:0] A_CTRL = 6'h20;
   localparam logic [RAW-1:0] A_STAT = 6'h21;
   localparam logic [RAW-1:0] A_CLR = 6'h22;
   localparam logic [RAW-1:0] A_IEN = 6'h23;
   localparam logic [RAW-1:0] A_ACT = 6'h24;

   // software trigger bits of the control register
   localparam int CTRL_SWT_LSB = 4;

   // channel configuration, bit 0 is en
   typedef struct packed {
      logic [3:0] tsel;
      logic reload;
      logic [1:0] dmode;
      logic [1:0] smode;
      logic [1:0] burst;
      logic en;
   } dmm_cfg_t;

   typedef struct packed {
      logic link23;
      logic link01;
      logic rr;
   } dmm_ctrl_t;

   typedef struct packed {
      logic req;
      logic we;
      dmm_addr_t addr;
      logic [7:0] wdata;
   } dmm_bus_t;

   localparam logic [1:0] AM_HOLD = 2'h0;
   localparam logic [1:0] AM_INC = 2'h1;
   localparam logic [1:0] AM_DEC = 2'h2;

   localparam logic [3:0] TSEL_PER = 4'h1;
   localparam logic [3:0] TSEL_EVT0 = 4'h2;

   localparam dmm_cfg_t CFG_RST = 12'h000;
   localparam dmm_ctrl_t CTRL_RST = 3'h0;
   localparam logic [15:0] BLK_RST = 16'h0001;
   localparam logic [7:0] RPT_RST = 8'h01;

   localparam dmm_addr_t EEP_LO = 16'h1000;
   localparam dmm_addr_t EEP_HI = 16'h1FFF;

   function automatic dmm_addr_t addr_step(input dmm_addr_t a, input logic [1:0] m);
      case (m)
         AM_INC: return a + 16'h0001;
         AM_DEC: return a - 16'h0001;
         default: return a;
      endcase
   endfunction

   function automatic logic [3:0] burst_len(input logic [1:0] b);
      return 4'h1 << b;
   endfunction

   function automatic logic in_eeprom(input dmm_addr_t a);
      return a >= EEP_LO && a <= EEP_HI;
   endfunction

   function automatic logic addr_bad(input dmm_addr_t a, input logic wr, input logic mapped);
      return in_eeprom(a) && (wr || !mapped);
   endfunction

   function automatic logic trig_hit(input logic [3:0] sel, input logic per,
                                     input logic [NEVT-1:0] evt);
      if (sel == TSEL_PER)
         return per;
      if (sel >= TSEL_EVT0 && sel < TSEL_EVT0 + 4'(NEVT))
         return evt[3'(sel - TSEL_EVT0)];
      return 1'b0;
   endfunction

endpackage

//--- design/dmm_prio_arb.sv
/*
   Channel chooser: fixed priority (lowest channel first) or round robin
   starting after the last served channel.
   Assumes N is a power of two; purely combinational.
*/
`timescale 1ns/100ps
module dmm_prio_arb #(
   parameter int N = 4,
   parameter int IW = $clog2(N)
) (
   input wire logic [N-1:0] req_i,
   input wire logic rr_i,
   input wire logic [IW-1:0] last_i,
   output logic [IW-1:0] gnt_o,
   output logic any_o
);

   always_comb
   begin
      logic [IW-1:0] idx;
      idx = '0;
      gnt_o = '0;
      any_o = |req_i;
      // scan from lowest rank upward so the best rank is taken last
      for (int k = N - 1; k >= 0; k--)
      begin
         idx = rr_i ? last_i + IW'(k + 1) : IW'(k);
         if (req_i[idx])
            gnt_o = idx;
      end
   end

endmodule // dmm_prio_arb

//--- design/dmm_irq_regs.sv
/*
   Sticky status flags, write-one-to-clear, enable mask and one level
   interrupt output.
   Assumes set pulses and register strobes come from the same clock.
*/
`timescale 1ns/100ps
module dmm_irq_regs #(
   parameter int W = 8
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] set_i,
   input wire logic clr_we_i,
   input wire logic [W-1:0] clr_i,
   input wire logic ien_we_i,
   input wire logic [W-1:0] ien_i,
   output logic [W-1:0] status_o,
   output logic [W-1:0] ien_o,
   output logic irq_o
);

   logic [W-1:0] status_q;
   logic [W-1:0] status_d;
   logic [W-1:0] ien_q;
   logic [W-1:0] ien_d;
   logic irq_q;

   // set wins over a clear in the same cycle
   assign status_d = (status_q & ~(clr_we_i ? clr_i : '0)) | set_i;
   assign ien_d = ien_we_i ? ien_i : ien_q;

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         status_q <= '0;
         ien_q <= '0;
         irq_q <= 1'b0;
      end
      else if (ce_i)
      begin
         status_q <= status_d;
         ien_q <= ien_d;
         irq_q <= |(status_d & ien_d);
      end
   end

   assign status_o = status_q;
   assign ien_o = ien_q;
   assign irq_o = irq_q;

   property p_set_sticky;
      @(posedge clock_i) disable iff (!nrst_i)
      ce_i && |set_i |=> (status_o & $past(set_i)) == $past(set_i);
   endproperty
   a_set_sticky: assert property (p_set_sticky) else $error("event flag not set");

   property p_flag_holds;
      @(posedge clock_i) disable iff (!nrst_i)
      !clr_we_i |=> (status_o & $past(status_o)) == $past(status_o);
   endproperty
   a_flag_holds: assert property (p_flag_holds) else $error("flag lost without clear");

endmodule // dmm_irq_regs

//--- design/dmm_direct_memory_mover.sv
/*
   Four-channel direct memory mover: channel registers, trigger capture,
   transfer engine on the shared data bus, linking and completion flags.
   Assumes a bus owner that grants bus_o.req via bus_gnt_i and returns
   read data on bus_rdata_i in the cycle after a granted read.
*/
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
// Functional notes
// - Four channels each keep their own settings and run independently.
// - A block is 1 to 65536 bytes long, with a written length of 0 meaning 65536.
// - A repeat count replays the block up to 256 times, so one run moves up to 16M bytes.
// - Each pointer steps up, steps down or stays put after every byte.
// - Source and destination pointers have separate step modes.
// - With reload set, both pointers return to their start values at the end of a run.
// - Each trigger moves a burst of 1, 2, 4 or 8 bytes.
// - Competing channels are ordered by software-chosen fixed or rotating priority.
// - Every read and write goes over the data bus shared with the processor.
// - Any address of the peripheral register space may be read or written.
// - A channel starts on a peripheral line, an event channel or software, selected per channel.
// - In a linked pair the end of one channel's run enables the other.
// - The eeprom window is read only while mapped and never written; flash is out of reach.
// - Any pairing of memory and peripheral as source and destination is allowed.
// - The bus request stands unchanged until the bus owner grants it.
module dmm_direct_memory_mover (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [dmm_pkg::RAW-1:0] reg_addr_i,
   input wire logic [dmm_pkg::DW-1:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [dmm_pkg::DW-1:0] reg_rdata_o,
   output dmm_pkg::dmm_bus_t bus_o,
   input wire logic bus_gnt_i,
   input wire logic [7:0] bus_rdata_i,
   input wire logic eep_mapped_i,
   input wire logic [dmm_pkg::NCH-1:0] per_trig_i,
   input wire logic [dmm_pkg::NEVT-1:0] evt_i,
   output logic irq_o
);

   localparam int NCH = dmm_pkg::NCH;
   localparam int DW = dmm_pkg::DW;

   typedef enum logic [2:0] {S_IDLE, S_CHK, S_RD, S_RDAT, S_WR} dmm_state_t;

   dmm_pkg::dmm_cfg_t cfg_q [NCH];
   dmm_pkg::dmm_ctrl_t ctrl_q;
   logic [15:0] blk_q [NCH];
   logic [7:0] rpt_q [NCH];
   dmm_pkg::dmm_addr_t src0_q [NCH];
   dmm_pkg::dmm_addr_t dst0_q [NCH];
   dmm_pkg::dmm_addr_t src_q [NCH];
   dmm_pkg::dmm_addr_t dst_q [NCH];
   logic [15:0] cnt_q [NCH];
   logic [7:0] rleft_q [NCH];
   logic [NCH-1:0] pend_q;

   dmm_state_t st_q;
   logic [1:0] ch_q;
   logic [1:0] last_q;
   logic [3:0] beat_q;
   dmm_pkg::dmm_bus_t bus_q;
   logic [DW-1:0] rdata_q;
   logic [DW-1:0] rd;

   logic ch_we;
   logic [1:0] wch;
   logic byte_done;
   logic blk_end;
   logic txn_end;
   logic burst_end;
   logic bad;
   logic abort;
   logic linked;
   logic [NCH-1:0] en_v;
   logic [NCH-1:0] trig_v;
   logic [NCH-1:0] swt_v;
   logic [NCH-1:0] done_set;
   logic [NCH-1:0] err_set;
   logic [1:0] arb_ch;
   logic arb_any;
   logic [2*NCH-1:0] status;
   logic [2*NCH-1:0] ien;

   assign ch_we = reg_we_i && !reg_addr_i[5];
   assign wch = reg_addr_i[4:3];

   // engine events of the current cycle
   assign byte_done = ce_i && st_q == S_WR && bus_gnt_i;
   assign blk_end = byte_done && cnt_q[ch_q] == 16'h0001;
   assign txn_end = blk_end && rleft_q[ch_q] == 8'h01;
   assign burst_end = byte_done && (beat_q == 4'h1 || blk_end);
   // no other window is fenced: registers, sram, any pairing
   assign bad = dmm_pkg::addr_bad(src_q[ch_q], 1'b0, eep_mapped_i)
      || dmm_pkg::addr_bad(dst_q[ch_q], 1'b1, eep_mapped_i);
   assign abort = ce_i && st_q == S_CHK && bad;
   assign linked = ch_q[1] ? ctrl_q.link23 : ctrl_q.link01;

   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         en_v[i] = cfg_q[i].en;
         trig_v[i] = dmm_pkg::trig_hit(cfg_q[i].tsel, per_trig_i[i], evt_i);
         swt_v[i] = reg_we_i && reg_addr_i == dmm_pkg::A_CTRL
            && reg_wdata_i[dmm_pkg::CTRL_SWT_LSB + i];
         done_set[i] = txn_end && ch_q == 2'(i);
         err_set[i] = abort && ch_q == 2'(i);
      end
   end

   dmm_prio_arb #(.N(NCH)) u_arb (
      .req_i(pend_q & en_v),
      .rr_i(ctrl_q.rr),
      .last_i(last_q),
      .gnt_o(arb_ch),
      .any_o(arb_any)
   );

   dmm_irq_regs #(.W(2*NCH)) u_irq (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .set_i({err_set, done_set}),
      .clr_we_i(reg_we_i && reg_addr_i == dmm_pkg::A_CLR),
      .clr_i(reg_wdata_i[2*NCH-1:0]),
      .ien_we_i(reg_we_i && reg_addr_i == dmm_pkg::A_IEN),
      .ien_i(reg_wdata_i[2*NCH-1:0]),
      .status_o(status),
      .ien_o(ien),
      .irq_o(irq_o)
   );

   // pending trigger per channel, a new trigger beats the clear
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         pend_q <= '0;
      else if (ce_i)
         for (int i = 0; i < NCH; i++)
         begin
            if (en_v[i] && (trig_v[i] || swt_v[i]))
               pend_q[i] <= 1'b1;
            else if (!en_v[i] || ((burst_end || abort) && ch_q == 2'(i)))
               pend_q[i] <= 1'b0;
         end
   end

   // configuration, enable handover of linked pairs
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         ctrl_q <= dmm_pkg::CTRL_RST;
         for (int i = 0; i < NCH; i++)
         begin
            cfg_q[i] <= dmm_pkg::CFG_RST;
            blk_q[i] <= dmm_pkg::BLK_RST;
            rpt_q[i] <= dmm_pkg::RPT_RST;
         end
      end
      else if (ce_i)
      begin
         if (reg_we_i && reg_addr_i == dmm_pkg::A_CTRL)
            ctrl_q <= reg_wdata_i[2:0];
         for (int i = 0; i < NCH; i++)
         begin
            if (ch_we && wch == 2'(i))
               case (reg_addr_i[2:0])
                  dmm_pkg::R_CFG: cfg_q[i] <= reg_wdata_i[11:0];
                  dmm_pkg::R_BLK: blk_q[i] <= reg_wdata_i[15:0];
                  dmm_pkg::R_RPT: rpt_q[i] <= reg_wdata_i[7:0];
                  default: ;
               endcase
            if ((txn_end || abort) && ch_q == 2'(i))
               cfg_q[i].en <= 1'b0;
            if (txn_end && linked && (ch_q ^ 2'h1) == 2'(i))
               cfg_q[i].en <= 1'b1;
         end
      end
   end

   // pointers and counters
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         for (int i = 0; i < NCH; i++)
         begin
            src0_q[i] <= '0;
            dst0_q[i] <= '0;
            src_q[i] <= '0;
            dst_q[i] <= '0;
            cnt_q[i] <= dmm_pkg::BLK_RST;
            rleft_q[i] <= dmm_pkg::RPT_RST;
         end
      else if (ce_i)
         for (int i = 0; i < NCH; i++)
         begin
            if (ch_we && wch == 2'(i))
               case (reg_addr_i[2:0])
                  dmm_pkg::R_BLK: cnt_q[i] <= reg_wdata_i[15:0];
                  dmm_pkg::R_RPT: rleft_q[i] <= reg_wdata_i[7:0];
                  dmm_pkg::R_SRC:
                  begin
                     src0_q[i] <= reg_wdata_i[15:0];
                     src_q[i] <= reg_wdata_i[15:0];
                  end
                  dmm_pkg::R_DST:
                  begin
                     dst0_q[i] <= reg_wdata_i[15:0];
                     dst_q[i] <= reg_wdata_i[15:0];
                  end
                  default: ;
               endcase
            if (byte_done && ch_q == 2'(i))
            begin
               src_q[i] <= dmm_pkg::addr_step(src_q[i], cfg_q[i].smode);
               dst_q[i] <= dmm_pkg::addr_step(dst_q[i], cfg_q[i].dmode);
               cnt_q[i] <= cnt_q[i] - 16'h0001;
               if (blk_end)
               begin
                  cnt_q[i] <= blk_q[i];
                  if (txn_end)
                  begin
                     rleft_q[i] <= rpt_q[i];
                     if (cfg_q[i].reload)
                     begin
                        src_q[i] <= src0_q[i];
                        dst_q[i] <= dst0_q[i];
                     end
                  end
                  else
                     rleft_q[i] <= rleft_q[i] - 8'h01;
               end
            end
         end
   end

   // transfer engine: check, read, capture, write
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         st_q <= S_IDLE;
         ch_q <= 2'h0;
         last_q <= 2'h3;
         beat_q <= 4'h0;
         bus_q <= '0;
      end
      else if (ce_i)
         unique case (st_q)
            S_IDLE:
               if (arb_any)
               begin
                  ch_q <= arb_ch;
                  last_q <= arb_ch;
                  beat_q <= dmm_pkg::burst_len(cfg_q[arb_ch].burst);
                  st_q <= S_CHK;
               end
            S_CHK:
               if (bad)
                  st_q <= S_IDLE;
               else
               begin
                  bus_q.req <= 1'b1;
                  bus_q.we <= 1'b0;
                  bus_q.addr <= src_q[ch_q];
                  st_q <= S_RD;
               end
            S_RD:
               if (bus_gnt_i)
               begin
                  bus_q.req <= 1'b0;
                  st_q <= S_RDAT;
               end
            S_RDAT:
            begin
               bus_q.req <= 1'b1;
               bus_q.we <= 1'b1;
               bus_q.addr <= dst_q[ch_q];
               bus_q.wdata <= bus_rdata_i;
               st_q <= S_WR;
            end
            S_WR:
               if (bus_gnt_i)
               begin
                  bus_q.req <= 1'b0;
                  bus_q.we <= 1'b0;
                  beat_q <= beat_q - 4'h1;
                  st_q <= burst_end ? S_IDLE : S_CHK;
               end
         endcase
   end

   // register read, data valid only in the cycle after the strobe
   always_comb
   begin
      rd = '0;
      if (!reg_addr_i[5])
         case (reg_addr_i[2:0])
            dmm_pkg::R_CFG: rd = DW'(cfg_q[wch]);
            dmm_pkg::R_BLK: rd = DW'(blk_q[wch]);
            dmm_pkg::R_RPT: rd = DW'(rpt_q[wch]);
            dmm_pkg::R_SRC: rd = DW'(src0_q[wch]);
            dmm_pkg::R_DST: rd = DW'(dst0_q[wch]);
            dmm_pkg::R_CSRC: rd = DW'(src_q[wch]);
            dmm_pkg::R_CDST: rd = DW'(dst_q[wch]);
            default: rd = DW'({rleft_q[wch], cnt_q[wch]});
         endcase
      else
         case (reg_addr_i)
            dmm_pkg::A_CTRL: rd = DW'(ctrl_q);
            dmm_pkg::A_STAT: rd = DW'(status);
            dmm_pkg::A_IEN: rd = DW'(ien);
            dmm_pkg::A_ACT: rd = DW'({pend_q, st_q != S_IDLE, ch_q});
            default: rd = '0;
         endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         rdata_q <= '0;
      else if (ce_i)
         rdata_q <= reg_re_i ? rd : '0;
   end

   assign reg_rdata_o = rdata_q;
   assign bus_o = bus_q;

   property p_no_eep_write;
      @(posedge clock_i) disable iff (!nrst_i)
      bus_o.req && bus_o.we |-> !dmm_pkg::in_eeprom(bus_o.addr);
   endproperty
   a_no_eep_write: assert property (p_no_eep_write) else $error("eeprom write");

   property p_eep_read;
      @(posedge clock_i) disable iff (!nrst_i)
      $rose(bus_o.req) && !bus_o.we && dmm_pkg::in_eeprom(bus_o.addr) |-> $past(eep_mapped_i);
   endproperty
   a_eep_read: assert property (p_eep_read) else $error("unmapped eeprom read");

   property p_req_hold;
      @(posedge clock_i) disable iff (!nrst_i)
      bus_o.req && !bus_gnt_i |=> bus_o.req && $stable(bus_o.addr) && $stable(bus_o.we);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped");

   property p_wr_copies;
      @(posedge clock_i) disable iff (!nrst_i)
      ce_i && bus_o.req && !bus_o.we && bus_gnt_i ##1 ce_i
         |=> bus_o.req && bus_o.we && bus_o.wdata == $past(bus_rdata_i);
   endproperty
   a_wr_copies: assert property (p_wr_copies) else $error("write data mismatch");

   property p_dst_inc;
      @(posedge clock_i) disable iff (!nrst_i)
      byte_done && !txn_end && cfg_q[ch_q].dmode == dmm_pkg::AM_INC && !ch_we
         |=> dst_q[$past(ch_q)] == $past(dst_q[ch_q]) + 16'h0001;
   endproperty
   a_dst_inc: assert property (p_dst_inc) else $error("dst not stepped up");

   property p_src_dec;
      @(posedge clock_i) disable iff (!nrst_i)
      byte_done && !txn_end && cfg_q[ch_q].smode == dmm_pkg::AM_DEC && !ch_we
         |=> src_q[$past(ch_q)] == $past(src_q[ch_q]) - 16'h0001;
   endproperty
   a_src_dec: assert property (p_src_dec) else $error("src not stepped down");

   property p_reload;
      @(posedge clock_i) disable iff (!nrst_i)
      txn_end && cfg_q[ch_q].reload && !ch_we
         |=> src_q[$past(ch_q)] == src0_q[$past(ch_q)] && dst_q[$past(ch_q)] == dst0_q[$past(ch_q)];
   endproperty
   a_reload: assert property (p_reload) else $error("pointers not reloaded");

   property p_link;
      @(posedge clock_i) disable iff (!nrst_i)
      txn_end && ch_q == 2'h0 && ctrl_q.link01 && !reg_we_i |=> cfg_q[1].en && !cfg_q[0].en;
   endproperty
   a_link: assert property (p_link) else $error("link handover missing");

   property p_fixed_prio;
      @(posedge clock_i) disable iff (!nrst_i)
      ce_i && st_q == S_IDLE && !ctrl_q.rr && pend_q[0] && en_v[0]
         |=> st_q == S_CHK && ch_q == 2'h0;
   endproperty
   a_fixed_prio: assert property (p_fixed_prio) else $error("channel 0 not first");

endmodule // dmm_direct_memory_mover

//--- dv/dmm_bus_mem.sv
/*
   Byte memory model of the shared data bus owner for the direct memory mover.
   Assumes one clock; grants after lat_i waiting cycles; answers reads next cycle.
*/
`timescale 1ns/100ps
module dmm_bus_mem (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire dmm_pkg::dmm_bus_t bus_i,
   input wire logic [1:0] lat_i,
   output logic gnt_o,
   output logic [7:0] rdata_o,
   output logic eep_wr_o
);
   logic [7:0] mem [0:65535];
   logic [1:0] wait_q;

   initial
   begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
   end

   assign gnt_o = bus_i.req && (wait_q >= lat_i);

   always @(posedge clock_i)
   begin
      if (!nrst_i || gnt_o)
         wait_q <= 2'h0;
      else if (bus_i.req)
         wait_q <= wait_q + 2'h1;
   end

   // read data valid one cycle only, toggles otherwise
   always @(posedge clock_i)
   begin
      if (!nrst_i)
         rdata_o <= 8'h00;
      else if (gnt_o && !bus_i.we)
         rdata_o <= mem[bus_i.addr];
      else
         rdata_o <= ~rdata_o;
   end

   always @(posedge clock_i)
   begin
      if (!nrst_i)
         eep_wr_o <= 1'b0;
      else if (gnt_o && bus_i.we)
      begin
         mem[bus_i.addr] <= bus_i.wdata;
         if (bus_i.addr >= 16'h1000 && bus_i.addr <= 16'h1FFF)
            eep_wr_o <= 1'b1;
      end
   end
endmodule // dmm_bus_mem

//--- dv/test_dmm_direct_memory_mover.sv
/*
   Self-checking bench of the direct memory mover: register tasks and transfers.
   Assumes the bus memory model dmm_bus_mem as the data bus owner.
*/
`timescale 1ns/100ps
module test_dmm_direct_memory_mover;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [5:0] reg_addr_i = 6'h00;
   logic [31:0] reg_wdata_i = 32'h00000000;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic [31:0] reg_rdata_o;
   dmm_pkg::dmm_bus_t bus_o;
   logic bus_gnt_i;
   logic [7:0] bus_rdata_i;
   logic eep_mapped_i = 1'b1;
   logic [3:0] per_trig_i = 4'h0;
   logic [7:0] evt_i = 8'h00;
   logic irq_o;
   logic [1:0] lat = 2'h0;
   logic ce = 1'b1;
   logic eep_wr;
   logic [31:0] v;
   int err_count = 0;
   int cmp_count = 0;

   always #2.5 clock_i = ~clock_i;

   dmm_direct_memory_mover dmm_direct_memory_mover_i (.clock_i(clock_i), .nrst_i(nrst_i),
      .ce_i(ce), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
      .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .bus_o(bus_o), .bus_gnt_i(bus_gnt_i),
      .bus_rdata_i(bus_rdata_i), .eep_mapped_i(eep_mapped_i), .per_trig_i(per_trig_i),
      .evt_i(evt_i), .irq_o(irq_o));

   dmm_bus_mem dmm_bus_mem_i (.clock_i(clock_i), .nrst_i(nrst_i), .bus_i(bus_o), .lat_i(lat),
      .gnt_o(bus_gnt_i), .rdata_o(bus_rdata_i), .eep_wr_o(eep_wr));

   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction

   function automatic logic [5:0] ra(input logic [1:0] ch, input logic [2:0] idx);
      return {1'b0, ch, idx};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      reg_we_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_we_i <= 1'b0;
      @(posedge clock_i);
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_re_i <= 1'b0;
      #1 d = reg_rdata_o;
      @(posedge clock_i);
   endtask

   task automatic wait_stat(input logic [31:0] m);
      for (int i = 0; i < 2000; i++)
      begin
         rd(dmm_pkg::A_STAT, v);
         if ((v & m) != 32'h0)
            break;
      end
      chk(v & m, m);
   endtask

   task automatic close_out;
      if (err_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      #100000;
      err_count++;
      close_out();
   end

   initial
   begin
      repeat (8) @(posedge clock_i);
      nrst_i <= 1'b1;
      @(posedge clock_i);
      rd(ra(0, dmm_pkg::R_CFG), v); chk(v, 32'h0);
      rd(ra(2, dmm_pkg::R_BLK), v); chk(v, 32'h1);
      // a write while the clock enable is low must be lost
      ce <= 1'b0;
      wr(ra(2, dmm_pkg::R_BLK), 32'h7);
      ce <= 1'b1;
      rd(ra(2, dmm_pkg::R_BLK), v); chk(v, 32'h1);
      rd(ra(3, dmm_pkg::R_RPT), v); chk(v, 32'h1);
      rd(6'h30, v); chk(v, 32'h0);
      wr(dmm_pkg::A_IEN, 32'h03);
      wr(ra(1, dmm_pkg::R_CFG), 32'h096);
      wr(ra(1, dmm_pkg::R_BLK), 32'h3);
      wr(ra(1, dmm_pkg::R_SRC), 32'h2100);
      wr(ra(1, dmm_pkg::R_DST), 32'h0040);
      wr(dmm_pkg::A_CTRL, 32'h2);
      wr(ra(0, dmm_pkg::R_CFG), 32'h12B);
      wr(ra(0, dmm_pkg::R_BLK), 32'h4);
      wr(ra(0, dmm_pkg::R_RPT), 32'h2);
      wr(ra(0, dmm_pkg::R_SRC), 32'h2000);
      wr(ra(0, dmm_pkg::R_DST), 32'h3000);
      lat <= 2'h2;
      per_trig_i <= 4'h1;
      wait_stat(32'h01);
      per_trig_i <= 4'h0;
      lat <= 2'h0;
      chk(32'(irq_o), 32'h1);
      for (int k = 0; k < 8; k++)
         chk(32'(dmm_bus_mem_i.mem[16'h3000 + k]), 32'(pat(16'h2000 + k)));
      rd(ra(0, dmm_pkg::R_CSRC), v); chk(v, 32'h2008);
      rd(ra(0, dmm_pkg::R_CDST), v); chk(v, 32'h3008);
      rd(ra(0, dmm_pkg::R_LEFT), v); chk(v, 32'h00020004);
      rd(ra(0, dmm_pkg::R_CFG), v); chk(v, 32'h12A);
      rd(ra(1, dmm_pkg::R_CFG), v); chk(v, 32'h097);
      wr(dmm_pkg::A_CLR, 32'h01);
      wr(dmm_pkg::A_STAT, 32'hFF);
      rd(dmm_pkg::A_STAT, v); chk(v, 32'h0);
      chk(32'(irq_o), 32'h0);
      wr(dmm_pkg::A_CTRL, 32'h22);
      wait_stat(32'h02);
      chk(32'(dmm_bus_mem_i.mem[16'h0040]), 32'(pat(16'h20FE)));
      rd(ra(1, dmm_pkg::R_CSRC), v); chk(v, 32'h2100);
      rd(ra(1, dmm_pkg::R_CDST), v); chk(v, 32'h0040);
      rd(ra(0, dmm_pkg::R_CFG), v); chk(v, 32'h12B);
      wr(dmm_pkg::A_CTRL, 32'h0);
      wr(ra(0, dmm_pkg::R_CFG), 32'h0);
      wr(dmm_pkg::A_CLR, 32'hFF);
      wr(ra(2, dmm_pkg::R_CFG), 32'h429);
      wr(ra(2, dmm_pkg::R_SRC), 32'h2000);
      wr(ra(2, dmm_pkg::R_DST), 32'h1000);
      evt_i <= 8'h04;
      @(posedge clock_i);
      evt_i <= 8'h00;
      wait_stat(32'h40);
      chk(32'(irq_o), 32'h0);
      chk(32'(eep_wr), 32'h0);
      rd(ra(2, dmm_pkg::R_CFG), v); chk(v, 32'h428);
      eep_mapped_i <= 1'b0;
      wr(ra(3, dmm_pkg::R_CFG), 32'h029);
      wr(ra(3, dmm_pkg::R_SRC), 32'h1000);
      wr(ra(3, dmm_pkg::R_DST), 32'h3100);
      wr(dmm_pkg::A_CTRL, 32'h80);
      wait_stat(32'h80);
      chk(32'(dmm_bus_mem_i.mem[16'h3100]), 32'(pat(16'h3100)));
      eep_mapped_i <= 1'b1;
      wr(dmm_pkg::A_CLR, 32'hFF);
      wr(ra(3, dmm_pkg::R_CFG), 32'h029);
      wr(ra(3, dmm_pkg::R_SRC), 32'h1000);
      wr(dmm_pkg::A_CTRL, 32'h80);
      wait_stat(32'h08);
      chk(32'(dmm_bus_mem_i.mem[16'h3100]), 32'(pat(16'h1000)));
      // rotating priority: serve channel 2 alone so it becomes the last served
      wr(ra(2, dmm_pkg::R_CFG), 32'h029);
      wr(ra(2, dmm_pkg::R_SRC), 32'h2200);
      wr(ra(2, dmm_pkg::R_DST), 32'h3300);
      wr(dmm_pkg::A_CTRL, 32'h41);
      wait_stat(32'h04);
      wr(dmm_pkg::A_CLR, 32'hFF);
      wr(ra(2, dmm_pkg::R_CFG), 32'h029);
      wr(ra(3, dmm_pkg::R_CFG), 32'h029);
      wr(ra(3, dmm_pkg::R_DST), 32'h3301);
      // both at once, pair 2/3 linked: channel 3 goes first, channel 2 writes last
      wr(dmm_pkg::A_CTRL, 32'hC5);
      wait_stat(32'h04);
      wait_stat(32'h08);
      chk(32'(dmm_bus_mem_i.mem[16'h3301]), 32'(pat(16'h2201)));
      rd(ra(3, dmm_pkg::R_CFG), v); chk(v, 32'h029);
      rd(ra(2, dmm_pkg::R_CFG), v); chk(v, 32'h028);
      close_out();
   end
endmodule // test_dmm_direct_memory_mover
